// File: common/upis_defines.svh
// named offsets, bit positions, reset values and counts of the pipe interrupt status block
// assumes inclusion by the package, the top module and the bench
`ifndef UPIS_DEFINES_SVH
`define UPIS_DEFINES_SVH
// register indices, byte address is four times the index
`define UPIS_IDX_MAIN_STATUS   8'h40
`define UPIS_IDX_READY_FLAGS   8'h46
`define UPIS_IDX_NOT_READY_SUMMARY_FLAGS    8'h48
`define UPIS_IDX_EMPTY_FLAGS   8'h4A
`define UPIS_IDX_READY_ENABLE  8'h36
`define UPIS_IDX_NOT_READY_SUMMARY_ENABLE   8'h38
`define UPIS_IDX_EMPTY_ENABLE  8'h3A
`define UPIS_IDX_MODE_CTRL     8'h30
`define UPIS_IDX_PIPE_DIR      8'h32
`define UPIS_IDX_EOT_MODE      8'h34
// main status fields
`define UPIS_BIT_STATE_FLAG    12
`define UPIS_BIT_STAGE_FLAG    11
`define UPIS_BIT_EMPTY_SUM     10
`define UPIS_BIT_NOT_READY_SUMMARY_SUM      9
`define UPIS_BIT_READY_SUM     8
`define UPIS_LSB_STATE_FIELD   4
`define UPIS_LSB_STAGE_FIELD   0
// mode control fields
`define UPIS_BIT_READY_MODE    0
`define UPIS_BIT_INT_LEVEL     1
// reset values and sizes
`define UPIS_NUM_PIPES         10
`define UPIS_REG_WIDTH         16
`define UPIS_RST_STATE_FIELD   3'h0
`define UPIS_RST_STAGE_FIELD   3'h0
`endif

// File: common/upis_pkg.sv
// types of the pipe interrupt status block
// assumes upis_defines.svh is on the include path
`include "upis_defines.svh"
package upis_pkg;
  typedef enum logic [2:0] {
    UPIS_DEV_POWERED    = 3'h0,
    UPIS_DEV_DEFAULT    = 3'h1,
    UPIS_DEV_ADDRESS    = 3'h2,
    UPIS_DEV_CONFIGURED = 3'h3,
    UPIS_DEV_SUSPENDED  = 3'h4
  } upis_dev_state_type;

  typedef enum logic [1:0] {
    UPIS_BUS_WAIT = 2'h1,
    UPIS_BUS_DONE = 2'h2
  } upis_bus_state_type;

  // usb-side events, strobes are one-cycle pulses
  typedef struct packed {
    logic       state_change;
    logic [2:0] usb_state_field;
    logic       stage_change;
    logic [2:0] control_stage_field;
    logic       status_stage;
    logic       port_ready_flag;
    logic       received_length_zero;
  } upis_usb_ev_type;

  // per-pipe events, one bit per pipe, pulses except buffer_access and cpu_busy
  typedef struct packed {
    logic [`UPIS_NUM_PIPES-1:0] packet_done;
    logic [`UPIS_NUM_PIPES-1:0] short_packet;
    logic [`UPIS_NUM_PIPES-1:0] count_reached;
    logic [`UPIS_NUM_PIPES-1:0] pid_mismatch;
    logic [`UPIS_NUM_PIPES-1:0] buffer_full;
    logic [`UPIS_NUM_PIPES-1:0] iso_flush;
    logic [`UPIS_NUM_PIPES-1:0] pipe_auto_clear;
    logic [`UPIS_NUM_PIPES-1:0] cpu_busy;
    logic [`UPIS_NUM_PIPES-1:0] transfer_read_done;
    logic [`UPIS_NUM_PIPES-1:0] zlp_empty;
    logic [`UPIS_NUM_PIPES-1:0] cpu_buffer_flush;
    logic [`UPIS_NUM_PIPES-1:0] empty_event;
    logic [`UPIS_NUM_PIPES-1:0] notready_event;
    logic [`UPIS_NUM_PIPES-1:0] buffer_access_flag;
  } upis_pipe_ev_type;
endpackage : upis_pkg

// File: rtl/upis_top.sv
// interrupt status flags, per-pipe flags and summaries of a usb peripheral controller
// assumes avalon-mm master with waitrequest, all inputs synchronous to clock_in
`timescale 1ns/1ps
`include "upis_defines.svh"
module upis_top #(
  parameter int NUM_PIPES = `UPIS_NUM_PIPES
) (
  input  wire logic                      clock_in,
  input  wire logic                      rst_in,
  input  wire logic [9:0]                avs_address_in,
  input  wire logic                      avs_read_in,
  input  wire logic                      avs_write_in,
  input  wire logic [31:0]               avs_writedata_in,
  input  wire logic [3:0]                avs_byteenable_in,
  input  wire upis_pkg::upis_usb_ev_type  usb_ev_in,
  input  wire upis_pkg::upis_pipe_ev_type pipe_ev_in,
  output logic [31:0]                    avs_readdata_out,
  output logic                           avs_waitrequest_out,
  output logic                           int_n_out
);
  localparam int W = `UPIS_REG_WIDTH;

  if (NUM_PIPES != `UPIS_NUM_PIPES) begin : g_bad_pipes
    $error("upis_top: NUM_PIPES must match the event struct width");
  end

  upis_pkg::upis_bus_state_type bus_state;
  logic [2:0]           usb_state_field;
  logic [2:0]           control_stage_field;
  logic                 state_change_flag;
  logic                 stage_change_flag;
  logic                 buffer_empty_summary;
  logic                 not_ready_summary;
  logic                 ready_summary;
  logic [NUM_PIPES-1:0] per_pipe_empty_flag;
  logic [NUM_PIPES-1:0] per_pipe_notready_flag;
  logic [NUM_PIPES-1:0] per_pipe_ready_flag;
  logic [NUM_PIPES-1:0] per_pipe_empty_enable;
  logic [NUM_PIPES-1:0] per_pipe_notready_enable;
  logic [NUM_PIPES-1:0] per_pipe_ready_enable;
  logic [NUM_PIPES-1:0] pipe_dir;
  logic [NUM_PIPES-1:0] end_of_transfer_mode;
  logic [NUM_PIPES-1:0] dir_prev;
  logic [NUM_PIPES-1:0] ready_pending;
  logic [NUM_PIPES-1:0] zlp_hold;
  logic [NUM_PIPES-1:0] ready_int_mask;
  logic                 ready_mode_select;
  logic                 interrupt_output_level_sel;
  logic                 any_int_prev;
  logic                 any_int;
  logic                 bus_done;
  logic                 wr_done;
  logic [7:0]           reg_index;
  logic [W-1:0]         wr_lanes;
  logic [W-1:0]         wr_data;
  logic [W-1:0]         clr_mask;
  logic [W-1:0]         rd_word;
  logic [W-1:0]         main_word;

  assign reg_index = avs_address_in[9:2];
  assign bus_done  = (bus_state == upis_pkg::UPIS_BUS_DONE);
  assign wr_done   = bus_done && avs_write_in;
  assign wr_lanes  = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign wr_data   = avs_writedata_in[W-1:0];
  // lanes not enabled count as written ones, so they clear nothing
  assign clr_mask  = ~wr_data & wr_lanes;

  // bus slave: one wait cycle, then the access completes at the low-waitrequest edge
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      bus_state           <= upis_pkg::UPIS_BUS_WAIT;
      avs_waitrequest_out <= 1'b1;
    end else begin
      case (bus_state)
        upis_pkg::UPIS_BUS_WAIT: begin
          if (avs_read_in || avs_write_in) begin
            bus_state           <= upis_pkg::UPIS_BUS_DONE;
            avs_waitrequest_out <= 1'b0;
          end
        end
        upis_pkg::UPIS_BUS_DONE: begin
          bus_state           <= upis_pkg::UPIS_BUS_WAIT;
          avs_waitrequest_out <= 1'b1;
        end
        default: begin
          bus_state           <= upis_pkg::UPIS_BUS_WAIT;
          avs_waitrequest_out <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    main_word = '0;
    main_word[`UPIS_BIT_STATE_FLAG] = state_change_flag;
    main_word[`UPIS_BIT_STAGE_FLAG] = stage_change_flag;
    main_word[`UPIS_BIT_EMPTY_SUM]  = buffer_empty_summary;
    main_word[`UPIS_BIT_NOT_READY_SUMMARY_SUM]   = not_ready_summary;
    main_word[`UPIS_BIT_READY_SUM]  = ready_summary;
    main_word[`UPIS_LSB_STATE_FIELD +: 3] = usb_state_field;
    main_word[`UPIS_LSB_STAGE_FIELD +: 3] = control_stage_field;
  end

  // unassigned high bits and unmapped addresses read zero
  always_comb begin
    rd_word = '0;
    case (reg_index)
      `UPIS_IDX_MAIN_STATUS:  rd_word = main_word;
      `UPIS_IDX_READY_FLAGS:  rd_word[NUM_PIPES-1:0] = per_pipe_ready_flag;
      `UPIS_IDX_NOT_READY_SUMMARY_FLAGS:   rd_word[NUM_PIPES-1:0] = per_pipe_notready_flag;
      `UPIS_IDX_EMPTY_FLAGS:  rd_word[NUM_PIPES-1:0] = per_pipe_empty_flag;
      `UPIS_IDX_READY_ENABLE: rd_word[NUM_PIPES-1:0] = per_pipe_ready_enable;
      `UPIS_IDX_NOT_READY_SUMMARY_ENABLE:  rd_word[NUM_PIPES-1:0] = per_pipe_notready_enable;
      `UPIS_IDX_EMPTY_ENABLE: rd_word[NUM_PIPES-1:0] = per_pipe_empty_enable;
      `UPIS_IDX_PIPE_DIR:     rd_word[NUM_PIPES-1:0] = pipe_dir;
      `UPIS_IDX_EOT_MODE:     rd_word[NUM_PIPES-1:0] = end_of_transfer_mode;
      `UPIS_IDX_MODE_CTRL: begin
        rd_word[`UPIS_BIT_READY_MODE] = ready_mode_select;
        rd_word[`UPIS_BIT_INT_LEVEL]  = interrupt_output_level_sel;
      end
      default: rd_word = '0;
    endcase
  end

  // read data is captured on the edge that drops waitrequest and stands while it is low
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0;
    end else if (!bus_done && avs_read_in) begin
      avs_readdata_out <= {16'h0, rd_word};
    end
  end

  // plain control registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      per_pipe_empty_enable      <= '0;
      per_pipe_notready_enable   <= '0;
      per_pipe_ready_enable      <= '0;
      pipe_dir                   <= '0;
      end_of_transfer_mode       <= '0;
      ready_mode_select          <= 1'b0;
      interrupt_output_level_sel <= 1'b0;
    end else if (wr_done && avs_byteenable_in[0]) begin
      case (reg_index)
        `UPIS_IDX_READY_ENABLE: per_pipe_ready_enable    <= wr_data[NUM_PIPES-1:0];
        `UPIS_IDX_NOT_READY_SUMMARY_ENABLE:  per_pipe_notready_enable <= wr_data[NUM_PIPES-1:0];
        `UPIS_IDX_EMPTY_ENABLE: per_pipe_empty_enable    <= wr_data[NUM_PIPES-1:0];
        `UPIS_IDX_PIPE_DIR:     pipe_dir                 <= wr_data[NUM_PIPES-1:0];
        `UPIS_IDX_EOT_MODE:     end_of_transfer_mode     <= wr_data[NUM_PIPES-1:0];
        `UPIS_IDX_MODE_CTRL: begin
          ready_mode_select          <= wr_data[`UPIS_BIT_READY_MODE];
          interrupt_output_level_sel <= wr_data[`UPIS_BIT_INT_LEVEL];
        end
        default: begin
        end
      endcase
    end
  end

  // state and stage transition flags; an event in the clearing cycle wins
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      usb_state_field     <= `UPIS_RST_STATE_FIELD;
      control_stage_field <= `UPIS_RST_STAGE_FIELD;
      state_change_flag   <= 1'b0;
      stage_change_flag   <= 1'b0;
    end else begin
      if (usb_ev_in.state_change) begin
        usb_state_field   <= usb_ev_in.usb_state_field;
        state_change_flag <= 1'b1;
      end else if (wr_done && reg_index == `UPIS_IDX_MAIN_STATUS
                   && clr_mask[`UPIS_BIT_STATE_FLAG]) begin
        state_change_flag <= 1'b0;
      end
      if (usb_ev_in.stage_change) begin
        control_stage_field <= usb_ev_in.control_stage_field;
        stage_change_flag   <= 1'b1;
      end else if (wr_done && reg_index == `UPIS_IDX_MAIN_STATUS
                   && clr_mask[`UPIS_BIT_STAGE_FLAG]) begin
        stage_change_flag <= 1'b0;
      end
    end
  end

  // summaries are recomputed every cycle and take no bus write
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      buffer_empty_summary <= 1'b0;
      not_ready_summary    <= 1'b0;
      ready_summary        <= 1'b0;
    end else begin
      buffer_empty_summary <= |(per_pipe_empty_flag & per_pipe_empty_enable);
      not_ready_summary    <= |(per_pipe_notready_flag & per_pipe_notready_enable);
      ready_summary <= |(per_pipe_ready_flag & per_pipe_ready_enable & ready_int_mask);
    end
  end

  for (genvar i = 0; i < NUM_PIPES; i++) begin : g_pipe
    logic tx_pipe;
    logic writable;
    logic raw_tx;
    logic raw_rx;
    logic raw_eot;
    logic raw_trig;
    logic fire;
    logic clr_ready;
    logic clr_empty;
    logic clr_not_ready_summary;

    assign writable = pipe_ev_in.buffer_access_flag[i];
    // the default control pipe never raises a transmit trigger
    assign tx_pipe  = pipe_dir[i] && (i != 0);
    assign raw_tx   = tx_pipe && ((pipe_dir[i] && !dir_prev[i])
                      || (pipe_ev_in.packet_done[i] && !writable)
                      || pipe_ev_in.iso_flush[i]
                      || (pipe_ev_in.pipe_auto_clear[i] && !writable));
    assign raw_rx   = !pipe_dir[i] && pipe_ev_in.packet_done[i]
                      && !pipe_ev_in.pid_mismatch[i]
                      && (pipe_ev_in.buffer_full[i] || pipe_ev_in.short_packet[i]
                          || pipe_ev_in.count_reached[i]);
    assign raw_eot  = !pipe_dir[i] && (pipe_ev_in.transfer_read_done[i]
                      || (pipe_ev_in.zlp_empty[i] && usb_ev_in.port_ready_flag
                          && usb_ev_in.received_length_zero));
    assign raw_trig = end_of_transfer_mode[i] ? raw_eot : (raw_tx || raw_rx);
    // a trigger seen while the cpu holds the other side waits for it to finish
    assign fire = (raw_trig || ready_pending[i]) && !pipe_ev_in.cpu_busy[i]
                  && !usb_ev_in.status_stage;
    assign clr_ready = wr_done && reg_index == `UPIS_IDX_READY_FLAGS
                       && clr_mask[i] && !ready_mode_select;
    assign clr_empty = wr_done && reg_index == `UPIS_IDX_EMPTY_FLAGS && clr_mask[i];
    assign clr_not_ready_summary  = wr_done && reg_index == `UPIS_IDX_NOT_READY_SUMMARY_FLAGS && clr_mask[i];
    assign ready_int_mask[i] = !(ready_mode_select && pipe_dir[i] && (i == 0));

    always_ff @(posedge clock_in) begin
      if (rst_in) begin
        dir_prev[i]      <= 1'b0;
        ready_pending[i] <= 1'b0;
      end else begin
        dir_prev[i] <= pipe_dir[i];
        if (ready_mode_select || fire) begin
          ready_pending[i] <= 1'b0;
        end else if (raw_trig && !usb_ev_in.status_stage) begin
          ready_pending[i] <= 1'b1;
        end
      end
    end

    always_ff @(posedge clock_in) begin
      if (rst_in) begin
        zlp_hold[i] <= 1'b0;
      end else if (!ready_mode_select || pipe_ev_in.cpu_buffer_flush[i]) begin
        zlp_hold[i] <= 1'b0;
      end else if (pipe_ev_in.zlp_empty[i]) begin
        zlp_hold[i] <= 1'b1;
      end
    end

    always_ff @(posedge clock_in) begin
      if (rst_in) begin
        per_pipe_ready_flag[i] <= 1'b0;
      end else if (ready_mode_select) begin
        per_pipe_ready_flag[i] <= writable || zlp_hold[i];
      end else if (fire) begin
        per_pipe_ready_flag[i] <= 1'b1;
      end else if (clr_ready) begin
        per_pipe_ready_flag[i] <= 1'b0;
      end
    end

    always_ff @(posedge clock_in) begin
      if (rst_in) begin
        per_pipe_empty_flag[i]    <= 1'b0;
        per_pipe_notready_flag[i] <= 1'b0;
      end else begin
        if (pipe_ev_in.empty_event[i]) begin
          per_pipe_empty_flag[i] <= 1'b1;
        end else if (clr_empty) begin
          per_pipe_empty_flag[i] <= 1'b0;
        end
        if (pipe_ev_in.notready_event[i]) begin
          per_pipe_notready_flag[i] <= 1'b1;
        end else if (clr_not_ready_summary) begin
          per_pipe_notready_flag[i] <= 1'b0;
        end
      end
    end
  end

  // level mode holds the pin low; edge mode gives one low cycle only when a request appears while none was pending
  assign any_int = state_change_flag || stage_change_flag || buffer_empty_summary
                   || not_ready_summary || ready_summary;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      any_int_prev <= 1'b0;
      int_n_out    <= 1'b1;
    end else begin
      any_int_prev <= any_int;
      if (interrupt_output_level_sel) begin
        int_n_out <= !any_int;
      end else begin
        int_n_out <= !(any_int && !any_int_prev);
      end
    end
  end

  sequence s_state_event;
    usb_ev_in.state_change;
  endsequence

  sequence s_ready_set;
    per_pipe_ready_flag[1] ##1 ready_summary;
  endsequence

  property p_state_flag;
    @(posedge clock_in) disable iff (rst_in)
      s_state_event |=> state_change_flag
        && usb_state_field == $past(usb_ev_in.usb_state_field);
  endproperty
  a_state_flag: assert property (p_state_flag) else $error("state flag not set");

  property p_stage_flag;
    @(posedge clock_in) disable iff (rst_in)
      usb_ev_in.stage_change |=> stage_change_flag
        && control_stage_field == $past(usb_ev_in.control_stage_field);
  endproperty
  a_stage_flag: assert property (p_stage_flag) else $error("stage flag not set");

  property p_summary_value;
    @(posedge clock_in) disable iff (rst_in)
      1'b1 |=> not_ready_summary
        == |($past(per_pipe_notready_flag) & $past(per_pipe_notready_enable));
  endproperty
  a_summary_value: assert property (p_summary_value) else $error("summary wrong");

  property p_summary_drop;
    @(posedge clock_in) disable iff (rst_in)
      (per_pipe_empty_flag & per_pipe_empty_enable) == '0 |=> !buffer_empty_summary;
  endproperty
  a_summary_drop: assert property (p_summary_drop) else $error("summary stuck");

  property p_high_bits_zero;
    @(posedge clock_in) disable iff (rst_in)
      !bus_done && avs_read_in && reg_index == `UPIS_IDX_READY_FLAGS
        |=> avs_readdata_out[31:NUM_PIPES] == '0;
  endproperty
  a_high_bits_zero: assert property (p_high_bits_zero) else $error("high bits set");

  property p_clear_by_zero;
    @(posedge clock_in) disable iff (rst_in)
      g_pipe[2].clr_empty && !pipe_ev_in.empty_event[2] |=> !per_pipe_empty_flag[2];
  endproperty
  a_clear_by_zero: assert property (p_clear_by_zero) else $error("flag not cleared");

  property p_ready_summary;
    @(posedge clock_in) disable iff (rst_in)
      !ready_mode_select && g_pipe[1].fire ##1 per_pipe_ready_enable[1]
        |-> s_ready_set;
  endproperty
  a_ready_summary: assert property (p_ready_summary) else $error("ready not raised");

  property p_no_ready_in_status;
    @(posedge clock_in) disable iff (rst_in)
      usb_ev_in.status_stage && !ready_mode_select
        |=> (per_pipe_ready_flag & ~$past(per_pipe_ready_flag)) == '0;
  endproperty
  a_no_ready_in_status: assert property (p_no_ready_in_status)
    else $error("ready during status stage");

  property p_mode1_track;
    @(posedge clock_in) disable iff (rst_in)
      ready_mode_select && !zlp_hold[4] |=> per_pipe_ready_flag[4]
        == $past(pipe_ev_in.buffer_access_flag[4]);
  endproperty
  a_mode1_track: assert property (p_mode1_track) else $error("ready not tracking");

  property p_level_pin;
    @(posedge clock_in) disable iff (rst_in)
      interrupt_output_level_sel && ready_summary |=> !int_n_out;
  endproperty
  a_level_pin: assert property (p_level_pin) else $error("pin not asserted");
endmodule : upis_top

// File: testbench/upis_host_model.sv
// avalon-mm master that stands in for the host cpu on the register bus
// assumes the slave answers each request by dropping waitrequest for one cycle
`timescale 1ns/1ps
module upis_host_model (
  input  wire logic        clock_in,
  input  wire logic        waitrequest_in,
  input  wire logic [31:0] readdata_in,
  output logic [9:0]       address_out,
  output logic             read_out,
  output logic             write_out,
  output logic [31:0]      writedata_out
);
  int timeouts = 0;

  initial begin
    address_out   = 10'h000;
    read_out      = 1'b0;
    write_out     = 1'b0;
    writedata_out = 32'h00000000;
  end

  // the request is held until the edge that sees waitrequest low, then released
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [15:0] wd,
                      output logic [15:0] rd);
    int n;
    @(posedge clock_in);
    address_out   <= {idx, 2'h0};
    writedata_out <= {16'h0000, wd};
    read_out      <= !w;
    write_out     <= w;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (waitrequest_in && n < 64);
    rd = readdata_in[15:0];
    if (waitrequest_in) timeouts++;
    read_out  <= 1'b0;
    write_out <= 1'b0;
  endtask : xfer
endmodule : upis_host_model

// File: testbench/usb_pipe_interrupt_status_tb.sv
// self-checking bench of the pipe interrupt status block
// assumes the register indices of upis_defines.svh and a 200 MHz clock
`timescale 1ns/1ps
`include "upis_defines.svh"
module usb_pipe_interrupt_status_tb;
  logic                       clock_in = 1'b0;
  logic                       rst_in = 1'b1;
  logic [9:0]                 addr;
  logic                       rd_en;
  logic                       wr_en;
  logic [31:0]                wdata;
  logic [31:0]                rdata;
  logic                       wait_req;
  logic                       int_n;
  upis_pkg::upis_usb_ev_type  usb_ev = '0;
  upis_pkg::upis_usb_ev_type  ulv = '0;
  upis_pkg::upis_usb_ev_type  u;
  upis_pkg::upis_pipe_ev_type pipe_ev = '0;
  upis_pkg::upis_pipe_ev_type lv = '0;
  upis_pkg::upis_pipe_ev_type pe;
  int                         failures = 0;
  int                         checks_done = 0;
  int                         p;
  int                         q;
  int                         c;
  logic [15:0]                base;
  logic [15:0]                r;

  initial begin
    forever #2.5 clock_in = ~clock_in;
  end

  upis_top i_upis_top (.clock_in(clock_in), .rst_in(rst_in), .avs_address_in(addr),
    .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'h3), .usb_ev_in(usb_ev), .pipe_ev_in(pipe_ev),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .int_n_out(int_n));
  upis_host_model i_upis_host_model (.clock_in(clock_in), .waitrequest_in(wait_req),
    .readdata_in(rdata), .address_out(addr), .read_out(rd_en), .write_out(wr_en),
    .writedata_out(wdata));

  function automatic logic [15:0] bitp(input int i);
    return 16'h0001 << i;
  endfunction : bitp

  task automatic summarize();
    failures += i_upis_host_model.timeouts;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [15:0] d);
    i_upis_host_model.xfer(w, idx, d, r);
    if (i_upis_host_model.timeouts != 0) begin
      $display("Error at %0t: bus request not answered", $time);
      summarize();
    end
  endtask : xfer

  task automatic rchk(input logic [7:0] idx, input logic [15:0] exp);
    xfer(1'b0, idx, 16'h0000);
    chk(r, exp);
  endtask : rchk

  // the pin is registered, so look at it once the edge has settled
  task automatic ichk(input logic exp);
    #1;
    chk({15'h0000, int_n}, {15'h0000, exp});
  endtask : ichk

  // pulses ride on top of the level inputs held in lv and ulv
  task automatic pulse(input upis_pkg::upis_pipe_ev_type e, input upis_pkg::upis_usb_ev_type v);
    @(posedge clock_in);
    pipe_ev <= upis_pkg::upis_pipe_ev_type'(lv | e);
    usb_ev  <= upis_pkg::upis_usb_ev_type'(ulv | v);
    @(posedge clock_in);
    pipe_ev <= lv;
    usb_ev  <= ulv;
    repeat (3) @(posedge clock_in);
  endtask : pulse

  initial begin
    c = $urandom(51444);
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    rchk(`UPIS_IDX_MAIN_STATUS, 16'h0000);
    for (int s = 0; s < 5; s++) begin
      u = '0;
      u.state_change = 1'b1;
      u.usb_state_field = 3'(s);
      pulse('0, u);
      rchk(`UPIS_IDX_MAIN_STATUS, 16'h1000 | 16'(s << 4));
      xfer(1'b1, `UPIS_IDX_MAIN_STATUS, 16'hEFFF);
    end
    c = $urandom_range(7, 0);
    u = '0;
    u.stage_change = 1'b1;
    u.control_stage_field = 3'(c);
    pulse('0, u);
    base = 16'h0040 | 16'(c);
    rchk(`UPIS_IDX_MAIN_STATUS, base | 16'h0800);
    xfer(1'b1, `UPIS_IDX_MAIN_STATUS, 16'hF7FF);
    $display("transition test done");
    p = $urandom_range(9, 0);
    q = (p + 1 + $urandom_range(8, 0)) % 10;
    xfer(1'b1, `UPIS_IDX_MODE_CTRL, 16'h0002);
    xfer(1'b1, `UPIS_IDX_NOT_READY_SUMMARY_ENABLE, bitp(p));
    xfer(1'b1, `UPIS_IDX_EMPTY_ENABLE, 16'h0004);
    pe = '0;
    pe.notready_event = 10'(bitp(p) | bitp(q));
    pe.empty_event = 10'h004;
    pulse(pe, '0);
    rchk(`UPIS_IDX_NOT_READY_SUMMARY_FLAGS, bitp(p) | bitp(q));
    rchk(`UPIS_IDX_EMPTY_FLAGS, 16'h0004);
    ichk(1'b0);
    xfer(1'b1, `UPIS_IDX_MAIN_STATUS, 16'hF9FF);
    rchk(`UPIS_IDX_MAIN_STATUS, base | 16'h0600);
    xfer(1'b1, `UPIS_IDX_NOT_READY_SUMMARY_FLAGS, ~bitp(p));
    rchk(`UPIS_IDX_NOT_READY_SUMMARY_FLAGS, bitp(q));
    rchk(`UPIS_IDX_MAIN_STATUS, base | 16'h0400);
    xfer(1'b1, `UPIS_IDX_EMPTY_FLAGS, 16'hFFFB);
    rchk(`UPIS_IDX_EMPTY_FLAGS, 16'h0000);
    rchk(`UPIS_IDX_MAIN_STATUS, base);
    ichk(1'b1);
    $display("summary test done");
    xfer(1'b1, `UPIS_IDX_READY_ENABLE, 16'h03FF);
    pe = '0;
    pe.pid_mismatch = 10'(bitp(p));
    pe.packet_done = 10'(bitp(p));
    pe.buffer_full = 10'(bitp(p));
    pulse(pe, '0);
    rchk(`UPIS_IDX_READY_FLAGS, 16'h0000);
    ulv.status_stage = 1'b1;
    pe = '0;
    pe.buffer_full = 10'(bitp(q));
    pe.packet_done = 10'(bitp(q));
    pulse(pe, '0);
    rchk(`UPIS_IDX_READY_FLAGS, 16'h0000);
    ulv = '0;
    lv.cpu_busy = 10'(bitp(p));
    pe = '0;
    pe.short_packet = 10'(bitp(p));
    pe.packet_done = 10'(bitp(p));
    pulse(pe, '0);
    rchk(`UPIS_IDX_READY_FLAGS, 16'h0000);
    lv = '0;
    pe = '0;
    pe.count_reached = 10'(bitp(q) | bitp(1));
    pe.packet_done = 10'(bitp(q) | bitp(1));
    pulse(pe, '0);
    rchk(`UPIS_IDX_READY_FLAGS, bitp(p) | bitp(q) | bitp(1));
    ichk(1'b0);
    rchk(`UPIS_IDX_MAIN_STATUS, base | 16'h0100);
    xfer(1'b1, `UPIS_IDX_READY_FLAGS, ~(bitp(p) | bitp(q) | bitp(1)));
    rchk(`UPIS_IDX_MAIN_STATUS, base);
    $display("ready mode 0 test done");
    // the default control pipe raises no transmit trigger
    xfer(1'b1, `UPIS_IDX_PIPE_DIR, bitp(q));
    rchk(`UPIS_IDX_READY_FLAGS, bitp(q) & 16'h03FE);
    xfer(1'b1, `UPIS_IDX_READY_FLAGS, ~bitp(q));
    lv.cpu_busy = 10'(bitp(q));
    pe = '0;
    pe.packet_done = 10'(bitp(q));
    pulse(pe, '0);
    rchk(`UPIS_IDX_READY_FLAGS, 16'h0000);
    lv = '0;
    pulse('0, '0);
    rchk(`UPIS_IDX_READY_FLAGS, bitp(q) & 16'h03FE);
    xfer(1'b1, `UPIS_IDX_READY_FLAGS, ~bitp(q));
    xfer(1'b1, `UPIS_IDX_PIPE_DIR, 16'h0000);
    $display("transmit test done");
    xfer(1'b1, `UPIS_IDX_EOT_MODE, bitp(p));
    pe = '0;
    pe.packet_done = 10'(bitp(p));
    pe.short_packet = 10'(bitp(p));
    pulse(pe, '0);
    rchk(`UPIS_IDX_READY_FLAGS, 16'h0000);
    pe = '0;
    pe.transfer_read_done = 10'(bitp(p));
    pulse(pe, '0);
    rchk(`UPIS_IDX_READY_FLAGS, bitp(p));
    xfer(1'b1, `UPIS_IDX_READY_FLAGS, ~bitp(p));
    ulv.port_ready_flag = 1'b1;
    ulv.received_length_zero = 1'b1;
    pe = '0;
    pe.zlp_empty = 10'(bitp(p));
    pulse(pe, '0);
    rchk(`UPIS_IDX_READY_FLAGS, bitp(p));
    ulv = '0;
    pe = '0;
    pe.cpu_buffer_flush = 10'(bitp(p));
    pulse(pe, '0);
    xfer(1'b1, `UPIS_IDX_READY_FLAGS, ~bitp(p));
    $display("end of transfer test done");
    xfer(1'b1, `UPIS_IDX_EOT_MODE, 16'h0000);
    xfer(1'b1, `UPIS_IDX_MODE_CTRL, 16'h0003);
    lv.buffer_access_flag = 10'(bitp(p));
    pulse('0, '0);
    rchk(`UPIS_IDX_READY_FLAGS, bitp(p));
    xfer(1'b1, `UPIS_IDX_READY_FLAGS, 16'h0000);
    rchk(`UPIS_IDX_READY_FLAGS, bitp(p));
    ichk(1'b0);
    lv = '0;
    pulse('0, '0);
    rchk(`UPIS_IDX_READY_FLAGS, 16'h0000);
    ichk(1'b1);
    pe = '0;
    pe.zlp_empty = 10'(bitp(q));
    pulse(pe, '0);
    rchk(`UPIS_IDX_READY_FLAGS, bitp(q));
    ichk(1'b0);
    pe = '0;
    pe.cpu_buffer_flush = 10'(bitp(q));
    pulse(pe, '0);
    rchk(`UPIS_IDX_READY_FLAGS, 16'h0000);
    $display("ready mode 1 test done");
    summarize();
  end
endmodule : usb_pipe_interrupt_status_tb
